// file: dv/flash_ctl_assertions.sv
`timescale 1ns/100ps
module flash_ctl_assertions #(
    parameter int TIMEOUT_LEN = flash_ctl_pkg::TIMEOUT_CYCLES
) (
    input wire logic                     i_clock,
    input wire logic                     i_srst,
    input wire logic                     i_scl,
    input wire logic                     i_sda,
    input wire logic                     o_sda,
    input wire logic                     o_sda_oe,
    input wire flash_ctl_pkg::led_pair_s i_short_sense,
    input wire flash_ctl_pkg::led_pair_s i_drain_fault,
    input wire logic                     i_thermal_shdn,
    input wire flash_ctl_pkg::led_pair_s o_led_drive,
    input wire flash_ctl_pkg::led_pair_s o_check_bias,
    input wire logic                     o_flash_on,
    input wire logic                     o_charge_pump_en
);
    import flash_ctl_pkg::*;
    logic [31:0] flash_cnt_q;
    logic [31:0] bias_cnt_q;
    always_ff @(posedge i_clock) begin
        flash_cnt_q <= (i_srst || !o_flash_on) ? '0 : flash_cnt_q + 1;
        bias_cnt_q  <= (i_srst || !(|o_check_bias)) ? '0 : bias_cnt_q + 1;
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // ****
    // Checks
    // ****
    a_sda_only_low: assert property (
        o_sda == 1'b0) else $error("sda value high");
    a_oe_scl_high: assert property (
        i_scl [*4] |-> $stable(o_sda_oe)) else $error("sda moved, scl high");
    a_thermal_pump: assert property (
        i_thermal_shdn [*4] |-> !o_charge_pump_en) else $error("pump on hot");
    a_thermal_flash: assert property (
        i_thermal_shdn [*4] |-> !$rose(o_flash_on)) else $error("flash hot");
    a_bias_pair: assert property (
        o_check_bias.led1 == o_check_bias.led2) else $error("bias unpaired");
    a_bias_width: assert property (
        $fell(|o_check_bias) |-> bias_cnt_q == 32'(CHECK_CYCLES))
        else $error("bias width wrong");
    a_flash_bound: assert property (
        flash_cnt_q <= 32'(TIMEOUT_LEN)) else $error("flash too long");
    a_drain_cut: assert property (
        i_drain_fault.led2 |-> ##5 !o_led_drive.led2) else $error("led2 on");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_srst |=> !o_sda_oe && !o_flash_on && o_led_drive == '0)
        else $error("active in reset");
    c_flash: cover property ($rose(o_flash_on));
    c_check: cover property ($fell(|o_check_bias));
    c_ack: cover property ($rose(o_sda_oe));
endmodule // flash_ctl_assertions

bind flash_ctl flash_ctl_assertions #(.TIMEOUT_LEN(TIMEOUT_LEN)) chk_u (
    .i_clock(i_clock), .i_srst(i_srst), .i_scl(i_scl), .i_sda(i_sda),
    .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_short_sense(i_short_sense),
    .i_drain_fault(i_drain_fault), .i_thermal_shdn(i_thermal_shdn),
    .o_led_drive(o_led_drive), .o_check_bias(o_check_bias),
    .o_flash_on(o_flash_on), .o_charge_pump_en(o_charge_pump_en));

// file: dv/flash_ctl_tb.sv
`timescale 1ns/100ps
module flash_ctl_tb;
    import flash_ctl_pkg::*;
    localparam int TO_LEN = 200;
    localparam logic [7:0] ADDR_W = {SLAVE_ADDR, 1'b0};
    localparam logic [7:0] ADDR_R = {SLAVE_ADDR, 1'b1};
    logic       i_clock, i_srst, thermal, scl, sda_low, sda_oe;
    logic       flash_on, pump_en, res_stb;
    logic [8:0] res;
    logic [7:0] st;
    led_pair_s  short_s, drain_s, led_drive, bias;
    logic [8:0] exp_q[$];
    int         num_errors = 0;
    int         compares = 0;
    wire        sda_line = !(sda_low || sda_oe);

    flash_ctl #(.TIMEOUT_LEN(TO_LEN)) dut_u (
        .i_clock(i_clock), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_line),
        .o_sda(), .o_sda_oe(sda_oe), .i_short_sense(short_s),
        .i_drain_fault(drain_s), .i_thermal_shdn(thermal),
        .o_led_drive(led_drive), .o_check_bias(bias),
        .o_flash_on(flash_on), .o_charge_pump_en(pump_en));
    i2c_host_model host_u (
        .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(sda_low),
        .o_res(res), .o_res_stb(res_stb));

    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    task automatic final_report;
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic note(input logic ok, input logic [8:0] g, e);
        compares++;
        if (!ok) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic check_byte(input logic [7:0] g, e);
        note(g === e, {1'b0, g}, {1'b0, e});
    endtask
    task automatic check_bits(input logic [1:0] g, e);
        note(g === e, {7'h00, g}, {7'h00, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask
    task automatic wr_b(input logic [7:0] b, input logic ack);
        exp_q.push_back({1'b1, 7'h00, ack});
        host_u.byte_wr(b);
    endtask
    task automatic reg_wr(input logic [7:0] sel, dat);
        host_u.start();
        wr_b(ADDR_W, 1'b0);
        wr_b(sel, 1'b0);
        wr_b(dat, 1'b0);
        host_u.stop();
        cyc(4);
    endtask
    task automatic status_rd(input logic [7:0] e);
        reg_wr(SEL_STATUS, 8'hff);
        host_u.start();
        wr_b(ADDR_R, 1'b0);
        exp_q.push_back({1'b0, e});
        host_u.byte_rd();
        host_u.stop();
        cyc(4);
    endtask
    always @(posedge res_stb) begin : watch
        logic [8:0] e;
        e = 9'h1ff;
        if (exp_q.size() > 0)
            e = exp_q.pop_front();
        if (e[8])
            check_bits({1'b0, res[0]}, {1'b0, e[0]});
        else
            check_byte(res[7:0], e[7:0]);
    end
    initial begin
        #400us;
        num_errors++;
        final_report();
    end
    initial begin
        i_srst = 1'b1;
        thermal = 1'b0;
        short_s = '0;
        drain_s = '0;
        st = STATUS_RESET;
        void'($urandom(92));
        cyc(12);
        i_srst = 1'b0;
        cyc(4);
        host_u.start();
        wr_b(8'h50, 1'b1);
        host_u.stop();
        reg_wr(SEL_MODE, 8'h02);
        reg_wr(SEL_PRIMARY, 8'h03);
        check_bits(led_drive, 2'b11);
        host_u.start();
        wr_b(ADDR_W, 1'b0);
        wr_b(SEL_PRIMARY, 1'b0);
        host_u.stop();
        cyc(4);
        check_bits(led_drive, 2'b11);
        reg_wr(SEL_PRIMARY, 8'h00);
        check_bits(led_drive, 2'b00);
        reg_wr(SEL_PRIMARY, 8'h03);
        cyc(2 * TO_LEN);
        check_bits(led_drive, 2'b11);
        status_rd(st);
        short_s = 2'b10;
        reg_wr(SEL_PRIMARY, 8'h04);
        check_bits(bias, 2'b11);
        cyc(CHECK_CYCLES);
        check_bits(bias, 2'b00);
        st[ST_SHORT1] = 1'b1;
        status_rd(st);
        reg_wr(SEL_PRIMARY, 8'h04);
        check_bits(bias, 2'b00);
        reg_wr(SEL_PRIMARY, 8'h00);
        reg_wr(SEL_PRIMARY, 8'h07);
        check_bits(bias, 2'b11);
        cyc(CHECK_CYCLES);
        check_bits(led_drive, 2'b01);
        reg_wr(SEL_STATUS, 8'($urandom));
        reg_wr(SEL_MODE, 8'h01);
        reg_wr(SEL_MODE, 8'h03);
        check_bits({1'b0, flash_on}, 2'b01);
        cyc(TO_LEN);
        check_bits({1'b0, flash_on}, 2'b00);
        st[ST_TIMEOUT] = 1'b1;
        reg_wr(SEL_MODE, 8'h02);
        check_bits(led_drive, 2'b01);
        drain_s = 2'b01;
        cyc(8);
        check_bits(led_drive, 2'b00);
        st[ST_DRAIN2] = 1'b1;
        check_bits({1'b0, pump_en}, 2'b01);
        thermal = 1'b1;
        cyc(8);
        check_bits({1'b0, pump_en}, 2'b00);
        reg_wr(SEL_MODE, 8'h01);
        reg_wr(SEL_MODE, 8'h03);
        check_bits({flash_on, pump_en}, 2'b00);
        st[ST_THERMAL] = 1'b1;
        status_rd(st);
        cyc(20);
        note(exp_q.size() == 0, 9'h000, 9'h000);
        final_report();
    end
endmodule // flash_ctl_tb

// file: dv/i2c_host_model.sv
`timescale 1ns/100ps
module i2c_host_model (
    input  wire logic  i_sda_line,
    output logic       o_scl,
    output logic       o_sda_low,
    output logic [8:0] o_res,
    output logic       o_res_stb
);
    localparam realtime HALF = 62.5;
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
        o_res = '0;
        o_res_stb = 1'b0;
    end
    // SDA moves mid low phase, clear of both SCL edges
    task automatic bit_io(input logic b, output logic r);
        #(HALF / 2) o_sda_low = !b;
        #(HALF / 2) o_scl = 1'b1;
        #(HALF) r = i_sda_line;
        o_scl = 1'b0;
    endtask
    task automatic put(input logic [8:0] v);
        o_res = v;
        o_res_stb = 1'b1;
        #1 o_res_stb = 1'b0;
    endtask
    task automatic start;
        o_sda_low = 1'b1;
        #(HALF) o_scl = 1'b0;
    endtask
    task automatic stop;
        #(HALF / 2) o_sda_low = 1'b1;
        #(HALF / 2) o_scl = 1'b1;
        #(HALF) o_sda_low = 1'b0;
        #(HALF);
    endtask
    task automatic byte_wr(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        put({1'b1, 7'h00, r});
    endtask
    task automatic byte_rd;
        logic [7:0] d;
        logic       r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        put({1'b0, d});
    endtask
endmodule // i2c_host_model

// file: rtl/flash_ctl.sv
`timescale 1ns/100ps
module flash_ctl #(
    parameter int TIMEOUT_LEN = flash_ctl_pkg::TIMEOUT_CYCLES
) (
    input  wire logic                     i_clock,
    input  wire logic                     i_srst,
    input  wire logic                     i_scl,
    input  wire logic                     i_sda,
    output logic                          o_sda,
    output logic                          o_sda_oe,
    input  wire flash_ctl_pkg::led_pair_s i_short_sense,
    input  wire flash_ctl_pkg::led_pair_s i_drain_fault,
    input  wire logic                     i_thermal_shdn,
    output flash_ctl_pkg::led_pair_s      o_led_drive,
    output flash_ctl_pkg::led_pair_s      o_check_bias,
    output logic                          o_flash_on,
    output logic                          o_charge_pump_en
);
    import flash_ctl_pkg::*;

    // Time out counter needs at least two states
    if (TIMEOUT_LEN < 2) begin : g_bad_len
        $error("TIMEOUT_LEN too small");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       scl_prev_q;
    logic       sda_prev_q;
    led_pair_s  short_m_q, short_s_q, drain_m_q, drain_s_q;
    logic       therm_m_q, therm_s_q;

    always_ff @(posedge i_clock) begin
        scl_sync_q <= {scl_sync_q[0], i_scl};
        sda_sync_q <= {sda_sync_q[0], i_sda};
        scl_prev_q <= scl_sync_q[1];
        sda_prev_q <= sda_sync_q[1];
        short_m_q  <= i_short_sense;
        short_s_q  <= short_m_q;
        drain_m_q  <= i_drain_fault;
        drain_s_q  <= drain_m_q;
        therm_m_q  <= i_thermal_shdn;
        therm_s_q  <= therm_m_q;
    end

    wire scl      = scl_sync_q[1];
    wire sda      = sda_sync_q[1];
    wire scl_rise = scl & ~scl_prev_q;
    wire scl_fall = ~scl & scl_prev_q;
    wire start_c  = scl & scl_prev_q & sda_prev_q & ~sda;
    wire stop_c   = scl & scl_prev_q & ~sda_prev_q & sda;

    // ****************************************
    // Serial slave
    // ****************************************
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_SEL, S_DATA, S_READ, S_IGNORE
    } bus_state_e;

    bus_state_e state_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic       ack_pend_q;
    logic       ack_drive_q;
    logic       rd_drive_q;
    logic [7:0] sel_q;
    logic [7:0] data_hold_q;
    logic       wr_pend_q;
    logic [7:0] rd_shift_q;
    logic       wr_strobe;
    logic [7:0] primary_q;
    logic [7:0] mode_q;
    logic [7:0] status_q;

    // Bits are taken only while an address or write byte is expected
    wire rx_state  = (state_q == S_ADDR) | (state_q == S_SEL)
                     | (state_q == S_DATA);
    wire rx_bit    = scl_rise & rx_state & ~ack_pend_q & ~ack_drive_q;
    wire byte_done = rx_bit & (bit_cnt_q == 4'h7);
    wire [7:0] rx_byte = {shift_q[6:0], sda};
    wire addr_hit  = (rx_byte[7:1] == SLAVE_ADDR);
    wire ack_end   = scl_fall & ack_drive_q;
    wire rd_last   = scl_fall & rd_drive_q & (bit_cnt_q == 4'h7);
    // Read returns the register last selected
    wire [7:0] rd_value = (sel_q == SEL_STATUS)  ? status_q
                        : (sel_q == SEL_PRIMARY) ? primary_q
                        : mode_q;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_q     <= S_IDLE;
            shift_q     <= 8'h00;
            bit_cnt_q   <= 4'h0;
            ack_pend_q  <= 1'b0;
            ack_drive_q <= 1'b0;
            rd_drive_q  <= 1'b0;
            sel_q       <= 8'h00;
            data_hold_q <= 8'h00;
            wr_pend_q   <= 1'b0;
            rd_shift_q  <= 8'h00;
        end else if (start_c) begin
            state_q     <= S_ADDR;
            bit_cnt_q   <= 4'h0;
            ack_pend_q  <= 1'b0;
            ack_drive_q <= 1'b0;
            rd_drive_q  <= 1'b0;
            wr_pend_q   <= 1'b0;
        end else if (stop_c) begin
            state_q     <= S_IDLE;
            ack_pend_q  <= 1'b0;
            ack_drive_q <= 1'b0;
            rd_drive_q  <= 1'b0;
            wr_pend_q   <= 1'b0;
        end else begin
            if (rx_bit) begin
                shift_q   <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 4'h1;
            end
            if (byte_done) begin
                bit_cnt_q  <= 4'h0;
                ack_pend_q <= 1'b1;
                case (state_q)
                    S_ADDR: begin
                        if (~addr_hit) begin
                            ack_pend_q <= 1'b0;
                            state_q    <= S_IGNORE;
                        end else if (rx_byte[0]) begin
                            state_q <= S_READ;
                        end else begin
                            state_q <= S_SEL;
                        end
                    end
                    S_SEL: begin
                        sel_q   <= rx_byte;
                        state_q <= S_DATA;
                    end
                    S_DATA: begin
                        data_hold_q <= rx_byte;
                        wr_pend_q   <= 1'b1;
                        state_q     <= S_IGNORE;
                    end
                    default: begin
                        state_q <= S_IGNORE;
                    end
                endcase
            end
            // Acknowledge holds SDA low across the ninth clock
            if (scl_fall & ack_pend_q) begin
                ack_pend_q  <= 1'b0;
                ack_drive_q <= 1'b1;
            end else if (ack_end) begin
                ack_drive_q <= 1'b0;
                wr_pend_q   <= 1'b0;
                if (state_q == S_READ) begin
                    rd_shift_q <= rd_value;
                    rd_drive_q <= 1'b1;
                    bit_cnt_q  <= 4'h0;
                end
            end else if (rd_last) begin
                // Master's acknowledge slot is left alone
                rd_drive_q <= 1'b0;
                state_q    <= S_IGNORE;
            end else if (scl_fall & rd_drive_q) begin
                rd_shift_q <= {rd_shift_q[6:0], 1'b1};
                bit_cnt_q  <= bit_cnt_q + 4'h1;
            end
        end
    end

    // Commit only at the end of the acknowledged data byte
    assign wr_strobe = ack_end & wr_pend_q;

    // open-drain only, the data pin is only ever pulled low
    assign o_sda    = 1'b0;
    assign o_sda_oe = ack_drive_q | (rd_drive_q & ~rd_shift_q[7]);

    // ****************************************
    // Registers
    // ****************************************
    wire wr_primary = wr_strobe & (sel_q == SEL_PRIMARY);
    wire wr_mode    = wr_strobe & (sel_q == SEL_MODE);

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            primary_q <= PRIMARY_RESET;
            mode_q    <= MODE_RESET;
        end else begin
            if (wr_primary) begin
                primary_q <= data_hold_q;
            end
            if (wr_mode) begin
                mode_q <= data_hold_q;
            end
        end
    end

    // ****************************************
    // LED check
    // ****************************************
    logic        trig_prev_q;
    logic [15:0] check_cnt_q;
    logic        checking_q;

    wire check_start = primary_q[CHECK_BIT] & ~trig_prev_q;
    wire check_end   = checking_q
                       & (check_cnt_q == 16'(CHECK_CYCLES - 1));

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            trig_prev_q <= 1'b0;
            check_cnt_q <= 16'h0000;
            checking_q  <= 1'b0;
        end else begin
            trig_prev_q <= primary_q[CHECK_BIT];
            if (check_start & ~checking_q) begin
                checking_q  <= 1'b1;
                check_cnt_q <= 16'h0000;
            end else if (check_end) begin
                checking_q <= 1'b0;
            end else if (checking_q) begin
                check_cnt_q <= check_cnt_q + 16'h0001;
            end
        end
    end

    // bias applies to both channels regardless of enables
    assign o_check_bias = '{led1: checking_q, led2: checking_q};

    // ****************************************
    // Flash time out
    // ****************************************
    logic [31:0] to_cnt_q;
    logic        flash_q;
    logic        go_prev_q;

    wire flash_sel   = mode_q[FLASH_SEL_BIT];
    wire flash_go    = mode_q[FLASH_GO_BIT];
    wire flash_start = flash_go & ~go_prev_q & flash_sel & ~therm_s_q;
    wire to_expire   = flash_q & flash_sel
                       & (to_cnt_q == 32'(TIMEOUT_LEN - 1));

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            to_cnt_q  <= 32'h0000_0000;
            flash_q   <= 1'b0;
            go_prev_q <= 1'b0;
        end else begin
            go_prev_q <= flash_go;
            if (flash_start) begin
                flash_q  <= 1'b1;
                to_cnt_q <= 32'h0000_0000;
            end else if (to_expire | ~flash_go | ~flash_sel | therm_s_q) begin
                flash_q <= 1'b0;
            end else if (flash_q) begin
                to_cnt_q <= to_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ****************************************
    // Fault status
    // ****************************************
    logic [7:0] status_set;
    always_comb begin
        status_set              = 8'h00;
        status_set[ST_SHORT1]   = check_end & short_s_q.led1;
        status_set[ST_SHORT2]   = check_end & short_s_q.led2;
        status_set[ST_TIMEOUT]  = to_expire;
        status_set[ST_DRAIN1]   = drain_s_q.led1;
        status_set[ST_DRAIN2]   = drain_s_q.led2;
        status_set[ST_THERMAL]  = therm_s_q;
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            status_q <= STATUS_RESET;
        end else begin
            status_q <= status_q | status_set;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    wire torch_ok = ~flash_sel & flash_go & ~therm_s_q;
    wire drive_on = flash_q | torch_ok;

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_led_drive      <= '0;
            o_flash_on       <= 1'b0;
            o_charge_pump_en <= 1'b0;
        end else begin
            o_led_drive.led1 <= drive_on & primary_q[LED1_EN_BIT]
                                & ~status_q[ST_SHORT1]
                                & ~status_q[ST_DRAIN1];
            o_led_drive.led2 <= drive_on & primary_q[LED2_EN_BIT]
                                & ~status_q[ST_SHORT2]
                                & ~status_q[ST_DRAIN2];
            o_flash_on       <= flash_q;
            o_charge_pump_en <= drive_on & ~therm_s_q;
        end
    end

endmodule // flash_ctl

// file: rtl/flash_ctl_pkg.sv
// Summary of operation
// - Slave only; never drives bus as master, only pulls SDA low.
// - Register write is address byte, register selector, then data byte.
// - Answers slave address 0111110; write byte 7c, read byte 7d.
// - Status register is read only; data written to it is dropped.
// - Read after status selection shifts status bits out on SDA.
// - Flash start arms a time out; overlong pulse cuts current, max 255 ms.
// - Torch/video mode disables the flash time out.
// - LED check starts only on rising edge of check trigger; 20 us bias.
// - Detected anode-cathode short disconnects that LED's current loop.
// - Check runs on both LEDs even when both output enables are clear.
// - On a fault the offending output is disabled and a status bit set.
// - Power transistor drain-ground monitored continuously; abnormal flags fault.
// - Thermal shutdown stops charge pump, blocks flash and torch starts.
// - Primary control register sits at selector 01.
package flash_ctl_pkg;

    // ****************************************
    // Bus addressing
    // ****************************************
    localparam logic [6:0] SLAVE_ADDR      = 7'h3e;
    localparam logic [7:0] SEL_PRIMARY     = 8'h01;
    localparam logic [7:0] SEL_MODE        = 8'h02;
    localparam logic [7:0] SEL_STATUS      = 8'h17;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int LED1_EN_BIT   = 0;
    localparam int LED2_EN_BIT   = 1;
    localparam int CHECK_BIT     = 2;
    localparam int FLASH_SEL_BIT = 0;
    localparam int FLASH_GO_BIT  = 1;
    localparam int ST_SHORT1     = 0;
    localparam int ST_SHORT2     = 1;
    localparam int ST_TIMEOUT    = 2;
    localparam int ST_DRAIN1     = 3;
    localparam int ST_DRAIN2     = 4;
    localparam int ST_THERMAL    = 5;

    localparam logic [7:0] PRIMARY_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET    = 8'h00;
    localparam logic [7:0] STATUS_RESET  = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_MHZ         = 125;
    localparam int TIMEOUT_MS      = 255;
    localparam int TIMEOUT_CYCLES  = TIMEOUT_MS * 1000 * CLK_MHZ;
    localparam int CHECK_US        = 20;
    localparam int CHECK_CYCLES    = CHECK_US * CLK_MHZ;

    typedef struct packed {
        logic led1;
        logic led2;
    } led_pair_s;

endpackage
